// ### logic/mdpwm_pkg.sv
// package for the per-motor pulse-width stage: register map, widths, reset values
package mdpwm_pkg;
  localparam int DATA_W = 8;
  localparam int PULSE_W = 11;
  localparam int NUM_MOTORS = 2;
  // register addresses of the device register map
  localparam logic [7:0] ADDR_PERIOD_A = 8'h00;
  localparam logic [7:0] ADDR_PULSE_HI_A = 8'h01;
  localparam logic [7:0] ADDR_PULSE_LO_A = 8'h02;
  localparam logic [7:0] ADDR_PERIOD_B = 8'h03;
  localparam logic [7:0] ADDR_PULSE_HI_B = 8'h04;
  localparam logic [7:0] ADDR_PULSE_LO_B = 8'h05;
  localparam logic [7:0] ADDR_WIDTH_A = 8'h07;
  localparam logic [7:0] ADDR_WIDTH_B = 8'h08;
  // pulse-count high byte fields
  localparam int PULSE_HI_BITS = 3;
  // reset values
  localparam logic [7:0] WIDTH_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [10:0] PULSE_RESET = 11'h000;
  typedef enum logic [1:0] {
    MDPWM_IDLE,
    MDPWM_RUN
  } mdpwm_state_t;
endpackage

// ### logic/mdpwm_channel.sv
// one motor channel: period divider, pulse-width comparator and pulse run counter
`timescale 1ns/1ps
module mdpwm_channel #(
  parameter int DATA_W = 8,
  parameter int PULSE_W = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerDownN,
  input wire logic [DATA_W-1:0] periodCount,
  input wire logic [DATA_W-1:0] pulseWidth,
  input wire logic [PULSE_W-1:0] pulseCount,
  input wire logic pulseLoad,
  output logic driveOut,
  output logic running
);

  mdpwm_pkg::mdpwm_state_t state_ff;
  mdpwm_pkg::mdpwm_state_t nxt_state;
  logic [DATA_W-1:0] phase_ff;
  logic [DATA_W-1:0] nxt_phase;
  logic [DATA_W-1:0] activeWidth_ff;
  logic [DATA_W-1:0] nxt_activeWidth;
  logic [PULSE_W-1:0] remain_ff;
  logic [PULSE_W-1:0] nxt_remain;
  logic drive_ff;
  logic nxt_drive;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic stopNow = pulseLoad && (pulseCount == '0);
  wire logic startNow = pulseLoad && (pulseCount != '0);
  wire logic periodEnd = (phase_ff >= periodCount - 8'h01);
  wire logic lastPulse = periodEnd && (remain_ff == 11'h001);
  // zero width means half period
  wire logic [DATA_W-1:0] halfWidth = DATA_W'(periodCount >> 1);
  wire logic [DATA_W-1:0] effWidth = (pulseWidth == '0) ? halfWidth : pulseWidth;
  // phase 0 of the next period, or the current phase plus one
  wire logic [DATA_W-1:0] phaseNext = periodEnd ? '0 : DATA_W'(phase_ff + 8'h01);

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    nxt_activeWidth = activeWidth_ff;
    nxt_remain = remain_ff;
    nxt_drive = 1'b0;
    unique case (state_ff)
      mdpwm_pkg::MDPWM_IDLE: begin
        if (startNow && periodCount != '0) begin
          nxt_state = mdpwm_pkg::MDPWM_RUN;
          nxt_phase = '0;
          nxt_activeWidth = effWidth;
          nxt_remain = pulseCount;
          nxt_drive = 1'b1;
        end
      end
      mdpwm_pkg::MDPWM_RUN: begin
        nxt_phase = phaseNext;
        if (periodEnd) begin
          nxt_activeWidth = effWidth;
          nxt_remain = PULSE_W'(remain_ff - 11'h001);
          nxt_drive = 1'b1;
        end else begin
          nxt_drive = (phaseNext < activeWidth_ff);
        end
        // a count reload on the last boundary keeps the run going
        if (lastPulse && !startNow) begin
          nxt_state = mdpwm_pkg::MDPWM_IDLE;
          nxt_drive = 1'b0;
        end
        if (startNow) begin
          nxt_remain = pulseCount;
        end
      end
    endcase
    if (stopNow || !powerDownN) begin
      nxt_state = mdpwm_pkg::MDPWM_IDLE;
      nxt_drive = 1'b0;
      nxt_phase = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= mdpwm_pkg::MDPWM_IDLE;
      phase_ff <= '0;
      activeWidth_ff <= '0;
      remain_ff <= '0;
      drive_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      activeWidth_ff <= nxt_activeWidth;
      remain_ff <= nxt_remain;
      drive_ff <= nxt_drive;
    end
  end

  assign driveOut = drive_ff;
  assign running = (state_ff == mdpwm_pkg::MDPWM_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  off_low_a: assert property (@(posedge clk) disable iff (rst)
    !running |-> !driveOut)
    else $error("drive high while channel idle");

  stop_now_a: assert property (@(posedge clk) disable iff (rst)
    stopNow |=> !driveOut && !running)
    else $error("zero pulse count did not stop channel");

  width_latch_a: assert property (@(posedge clk) disable iff (rst)
    running && !periodEnd && !stopNow && powerDownN |=> $stable(activeWidth_ff))
    else $error("pulse width changed inside a period");

  pd_low_a: assert property (@(posedge clk) disable iff (rst)
    !powerDownN |=> !driveOut)
    else $error("drive high after power down");
endmodule

// ### logic/mdpwm_top.sv
// two-motor pulse-width stage: register file on the internal write port plus two channels
// Behaviour
// - each motor has its own pulse-width value that its channel latches at the start of each period.
// - the two motors' pulse-width settings are fully independent of each other.
// - the pulse-width registers read zero after reset and while power-down is held low.
// - a pulse-width value of zero gives a high time of half the period count, rounded down.
// - a nonzero value below the period count gives a high time of exactly that many clock cycles per period.
// - the duty cycle follows from the pulse-width value and period count, not a fixed scale.
// - the output period is the clock divided by the programmed period count.
// - writing a zero pulse count stops the motor at once and forces its output low.
// - a motor that is off or powered down drives its output low.
`timescale 1ns/1ps
module mdpwm_top #(
  parameter int DATA_W = mdpwm_pkg::DATA_W,
  parameter int PULSE_W = mdpwm_pkg::PULSE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic powerDownN,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic [1:0] driveOut,
  output logic [1:0] running
);

  logic [DATA_W-1:0] width_ff [2];
  logic [DATA_W-1:0] period_ff [2];
  logic [PULSE_W-1:0] pulse_ff [2];
  logic [PULSE_W-1:0] nxt_pulse [2];
  logic [1:0] pulseLoad;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // strobe is an argument so the decode wires follow it, not only the address
  function automatic logic hit(input logic we, input logic [7:0] a, input logic [7:0] ref_addr);
    hit = we && (a == ref_addr);
  endfunction

  wire logic [1:0] wrWidth = {hit(regWrite, regAddr, mdpwm_pkg::ADDR_WIDTH_B),
                              hit(regWrite, regAddr, mdpwm_pkg::ADDR_WIDTH_A)};
  wire logic [1:0] wrPeriod = {hit(regWrite, regAddr, mdpwm_pkg::ADDR_PERIOD_B),
                               hit(regWrite, regAddr, mdpwm_pkg::ADDR_PERIOD_A)};
  wire logic [1:0] wrPulseHi = {hit(regWrite, regAddr, mdpwm_pkg::ADDR_PULSE_HI_B),
                                hit(regWrite, regAddr, mdpwm_pkg::ADDR_PULSE_HI_A)};
  wire logic [1:0] wrPulseLo = {hit(regWrite, regAddr, mdpwm_pkg::ADDR_PULSE_LO_B),
                                hit(regWrite, regAddr, mdpwm_pkg::ADDR_PULSE_LO_A)};

  // the low byte write launches the run, so high then low is the write order
  always_comb begin
    for (int m = 0; m < 2; m++) begin
      nxt_pulse[m] = pulse_ff[m];
      if (wrPulseHi[m]) begin
        nxt_pulse[m][PULSE_W-1:8] = regWrData[mdpwm_pkg::PULSE_HI_BITS-1:0];
      end
      if (wrPulseLo[m]) begin
        nxt_pulse[m][7:0] = regWrData;
      end
    end
  end
  assign pulseLoad = wrPulseLo;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int m = 0; m < 2; m++) begin
        width_ff[m] <= mdpwm_pkg::WIDTH_RESET;
        period_ff[m] <= mdpwm_pkg::PERIOD_RESET;
        pulse_ff[m] <= mdpwm_pkg::PULSE_RESET;
      end
    end else if (!powerDownN) begin
      for (int m = 0; m < 2; m++) begin
        width_ff[m] <= mdpwm_pkg::WIDTH_RESET;
        period_ff[m] <= mdpwm_pkg::PERIOD_RESET;
        pulse_ff[m] <= mdpwm_pkg::PULSE_RESET;
      end
    end else begin
      for (int m = 0; m < 2; m++) begin
        if (wrWidth[m]) begin
          width_ff[m] <= regWrData;
        end
        if (wrPeriod[m]) begin
          period_ff[m] <= regWrData;
        end
        pulse_ff[m] <= nxt_pulse[m];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback
  always_comb begin
    nxt_rdData = rdData_ff;
    if (regRead) begin
      unique case (regAddr)
        mdpwm_pkg::ADDR_WIDTH_A: nxt_rdData = width_ff[0];
        mdpwm_pkg::ADDR_WIDTH_B: nxt_rdData = width_ff[1];
        mdpwm_pkg::ADDR_PERIOD_A: nxt_rdData = period_ff[0];
        mdpwm_pkg::ADDR_PERIOD_B: nxt_rdData = period_ff[1];
        mdpwm_pkg::ADDR_PULSE_LO_A: nxt_rdData = pulse_ff[0][7:0];
        mdpwm_pkg::ADDR_PULSE_LO_B: nxt_rdData = pulse_ff[1][7:0];
        mdpwm_pkg::ADDR_PULSE_HI_A: nxt_rdData = {5'h00, pulse_ff[0][PULSE_W-1:8]};
        mdpwm_pkg::ADDR_PULSE_HI_B: nxt_rdData = {5'h00, pulse_ff[1][PULSE_W-1:8]};
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end
  assign regRdData = rdData_ff;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    mdpwm_channel #(
      .DATA_W(DATA_W),
      .PULSE_W(PULSE_W)
    ) u_ch (
      .clk(clk),
      .rst(rst),
      .powerDownN(powerDownN),
      .periodCount(period_ff[g]),
      .pulseWidth(width_ff[g]),
      .pulseCount(nxt_pulse[g]),
      .pulseLoad(pulseLoad[g]),
      .driveOut(driveOut[g]),
      .running(running[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  pd_clear_a: assert property (@(posedge clk) disable iff (rst)
    !powerDownN |=> width_ff[0] == 8'h00 && width_ff[1] == 8'h00)
    else $error("pulse width not cleared in power down");

  width_indep_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrWidth[0] |=> $stable(width_ff[1]))
    else $error("motor A write disturbed motor B width");

  width_store_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrWidth[1] |=> width_ff[1] == $past(regWrData))
    else $error("pulse width write not stored");

  pd_outputs_a: assert property (@(posedge clk) disable iff (rst)
    !powerDownN |=> driveOut == 2'b00 && running == 2'b00)
    else $error("outputs active in power down");

  width_a_store_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrWidth[0] |=> width_ff[0] == $past(regWrData))
    else $error("motor A pulse width write not stored");

  width_b_keep_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrWidth[1] |=> $stable(width_ff[0]))
    else $error("motor B write disturbed motor A width");

  period_store_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrPeriod[0] |=> period_ff[0] == $past(regWrData))
    else $error("period write not stored");

  period_indep_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrPeriod[0] |=> $stable(period_ff[1]))
    else $error("motor A period write disturbed motor B");

  count_lo_store_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrPulseLo[0] |=> pulse_ff[0][7:0] == $past(regWrData))
    else $error("pulse count low byte not stored");

  count_hi_store_a: assert property (@(posedge clk) disable iff (rst)
    powerDownN && wrPulseHi[1]
      |=> pulse_ff[1][PULSE_W-1:8] == $past(regWrData[mdpwm_pkg::PULSE_HI_BITS-1:0]))
    else $error("pulse count high byte not stored");

  pd_regs_clear_a: assert property (@(posedge clk) disable iff (rst)
    !powerDownN |=> period_ff[0] == 8'h00 && period_ff[1] == 8'h00
      && pulse_ff[0] == '0 && pulse_ff[1] == '0)
    else $error("period or pulse count not cleared in power down");

  rd_hold_a: assert property (@(posedge clk) disable iff (rst)
    !regRead |=> $stable(regRdData))
    else $error("read data changed without a read");

  rd_width_a: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == mdpwm_pkg::ADDR_WIDTH_B |=> regRdData == $past(width_ff[1]))
    else $error("pulse width B read back wrong");

  rd_count_hi_a: assert property (@(posedge clk) disable iff (rst)
    regRead && regAddr == mdpwm_pkg::ADDR_PULSE_HI_A
      |=> regRdData == {5'h00, $past(pulse_ff[0][PULSE_W-1:8])})
    else $error("pulse count high byte read back wrong");

  ////////////////////////////////////////////////////////////////////////////
  // run control sequences
  sequence mdpwm_start_a_s;
    !running[0] && powerDownN && pulseLoad[0] && nxt_pulse[0] != '0 && period_ff[0] != 8'h00;
  endsequence

  sequence mdpwm_drive_a_s;
    running[0] && driveOut[0];
  endsequence

  sequence mdpwm_reload_a_s;
    running[0] && powerDownN && pulseLoad[0] && nxt_pulse[0] != '0;
  endsequence

  sequence mdpwm_stop_b_s;
    pulseLoad[1] && nxt_pulse[1] == '0;
  endsequence

  run_start_a: assert property (@(posedge clk) disable iff (rst)
    mdpwm_start_a_s |=> mdpwm_drive_a_s)
    else $error("run did not start high at phase zero");

  run_reload_a: assert property (@(posedge clk) disable iff (rst)
    mdpwm_reload_a_s |=> running[0])
    else $error("count reload ended the run");

  zero_period_a: assert property (@(posedge clk) disable iff (rst)
    !running[0] && pulseLoad[0] && period_ff[0] == 8'h00 |=> !running[0])
    else $error("run started with a zero period");

  stop_b_a: assert property (@(posedge clk) disable iff (rst)
    mdpwm_stop_b_s |=> running[1] == 1'b0 && driveOut[1] == 1'b0)
    else $error("zero pulse count did not stop motor B");
endmodule

// ### bench/mdpwm_motor_model.sv
// motor stage model: measures high time, period and pulse count on one drive line
`timescale 1ns/1ps
module mdpwm_motor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive,
  output logic [15:0] hiLen,
  output logic [15:0] perLen,
  output logic [15:0] nPulses
);
  logic [15:0] hiCnt;
  logic [15:0] perCnt;
  logic last;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiCnt <= 16'h0000;
      perCnt <= 16'h0000;
      hiLen <= 16'h0000;
      perLen <= 16'h0000;
      nPulses <= 16'h0000;
      last <= 1'b0;
    end else begin
      last <= drive;
      if (drive && !last) begin
        perLen <= perCnt;
        perCnt <= 16'h0001;
        nPulses <= nPulses + 16'h0001;
      end else begin
        perCnt <= perCnt + 16'h0001;
      end
      if (drive) begin
        hiCnt <= hiCnt + 16'h0001;
      end else if (last) begin
        hiLen <= hiCnt;
        hiCnt <= 16'h0000;
      end
    end
  end
endmodule

// ### bench/motor_duty_cycle_pwm_test.sv
// self-checking bench for the two-motor pulse-width stage
`timescale 1ns/1ps
module motor_duty_cycle_pwm_test;
  localparam logic [7:0] PA = mdpwm_pkg::ADDR_PERIOD_A;
  localparam logic [7:0] WA = mdpwm_pkg::ADDR_WIDTH_A;
  localparam logic [7:0] HIA = mdpwm_pkg::ADDR_PULSE_HI_A;
  localparam logic [7:0] LOA = mdpwm_pkg::ADDR_PULSE_LO_A;
  logic clk;
  logic rst;
  logic powerDownN;
  logic regWrite;
  logic regRead;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic [1:0] driveOut;
  logic [1:0] running;
  logic [15:0] hiLen [2];
  logic [15:0] perLen [2];
  logic [15:0] nPulses [2];
  logic [15:0] startCnt;
  logic [23:0] rows [5];
  int failures;
  int nTests;
  mdpwm_top u_mdpwm_top (.clk(clk), .rst(rst), .powerDownN(powerDownN), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .driveOut(driveOut), .running(running));
  mdpwm_motor_model u_mdpwm_motor_model_a (.clk(clk), .rst(rst), .drive(driveOut[0]),
    .hiLen(hiLen[0]), .perLen(perLen[0]), .nPulses(nPulses[0]));
  mdpwm_motor_model u_mdpwm_motor_model_b (.clk(clk), .rst(rst), .drive(driveOut[1]),
    .hiLen(hiLen[1]), .perLen(perLen[1]), .nPulses(nPulses[1]));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask
  task automatic wait_idle();
    #1;
    for (int i = 0; i < 3000 && running !== 2'b00; i++) begin
      @(posedge clk);
      #1;
    end
    if (running !== 2'b00) begin
      failures++;
      $display("[FAIL] run end expected 0 seen %b", running);
      print_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    // period, width, expected high cycles
    rows = '{24'h10_00_08, 24'h10_01_01, 24'h10_08_08, 24'h0b_00_05, 24'h14_03_03};
    failures = 0;
    nTests = 0;
    rst = 1'b1;
    powerDownN = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(WA, d);
    chk("width A reset", {8'h00, d}, 16'h0000);
    rd(mdpwm_pkg::ADDR_WIDTH_B, d);
    chk("width B reset", {8'h00, d}, 16'h0000);
    rd(8'h10, d);
    chk("unmapped", {8'h00, d}, 16'h0000);
    for (int r = 0; r < 5; r++) begin
      startCnt = nPulses[0];
      wr(PA, rows[r][23:16]);
      wr(WA, rows[r][15:8]);
      wr(mdpwm_pkg::ADDR_PERIOD_B, 8'h0c);
      wr(mdpwm_pkg::ADDR_WIDTH_B, 8'h02);
      rd(WA, d);
      chk("width A", {8'h00, d}, {8'h00, rows[r][15:8]});
      wr(LOA, 8'h03);
      wr(mdpwm_pkg::ADDR_PULSE_LO_B, 8'h03);
      wait_idle();
      chk("high A", hiLen[0], {8'h00, rows[r][7:0]});
      chk("period A", perLen[0], {8'h00, rows[r][23:16]});
      chk("pulses A", nPulses[0] - startCnt, 16'h0003);
      chk("high B", hiLen[1], 16'h0002);
      chk("period B", perLen[1], 16'h000c);
      chk("idle", {14'h0000, driveOut}, 16'h0000);
    end
    // width change in mid-period
    wr(PA, 8'h10);
    wr(WA, 8'h02);
    wr(LOA, 8'h04);
    wr(WA, 8'h06);
    repeat (8) @(posedge clk);
    #1;
    chk("high old width", hiLen[0], 16'h0002);
    wait_idle();
    chk("high new width", hiLen[0], 16'h0006);
    // long run stopped by a zero count
    wr(HIA, 8'h01);
    wr(LOA, 8'h00);
    repeat (20) @(posedge clk);
    #1;
    chk("long run", {15'h0000, running[0]}, 16'h0001);
    wr(HIA, 8'h00);
    wr(LOA, 8'h00);
    @(posedge clk);
    #1;
    chk("stop", {14'h0000, running[0], driveOut[0]}, 16'h0000);
    // standby in mid-run
    wr(HIA, 8'h01);
    wr(LOA, 8'h00);
    wr(WA, 8'h05);
    powerDownN <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("standby", {12'h000, running, driveOut}, 16'h0000);
    @(posedge clk);
    powerDownN <= 1'b1;
    rd(WA, d);
    chk("width after standby", {8'h00, d}, 16'h0000);
    // period was cleared by standby, so a start is refused
    wr(LOA, 8'h02);
    @(posedge clk);
    #1;
    chk("zero period", {15'h0000, running[0]}, 16'h0000);
    print_verdict();
  end
endmodule
